// [core/uxra_pkg.sv]
// Shared constants and types for the extended register access block
package uxra_pkg;
  localparam int NumChan = 4;
  // Register addresses (3-bit)
  localparam logic [2:0] AddrDivLow = 3'h0;
  localparam logic [2:0] AddrDivHigh = 3'h1;
  localparam logic [2:0] AddrEnhanced = 3'h2;
  localparam logic [2:0] AddrLineCtrl = 3'h3;
  localparam logic [2:0] AddrModemCtrl = 3'h4;
  localparam logic [2:0] AddrIntEnable = 3'h1;
  localparam logic [2:0] AddrFifoCtrl = 3'h2;
  localparam logic [2:0] AddrResume1 = 3'h4;
  localparam logic [2:0] AddrResume2 = 3'h5;
  localparam logic [2:0] AddrStop1 = 3'h6;
  localparam logic [2:0] AddrStop2 = 3'h7;
  localparam logic [2:0] AddrThreshold = 3'h6;
  localparam logic [2:0] AddrTrigger = 3'h7;
  localparam logic [2:0] AddrReady = 3'h7;
  // Line control values that open register banks
  localparam logic [7:0] LineEnhancedKey = 8'hbf;
  localparam int LineDivLatchBit = 7;
  // Field positions
  localparam int SleepBit = 4;
  localparam int EnhEnableBit = 4;
  localparam int McrReadyEnBit = 2;
  localparam int McrLoopBit = 4;
  localparam int McrBankBit = 6;
  localparam int McrPrescaleBit = 7;
  localparam int EfrAutoReqBit = 6;
  localparam int FcrTxTrigLo = 4;
  localparam int FcrRxTrigLo = 6;
  // Reset values
  localparam logic [7:0] ResetByte = 8'h00;
  localparam logic [7:0] ResetLineCtrl = 8'h1d;
  localparam logic [15:0] ResetDivisor = 16'h0000;
  // Level unit: one nibble step is four bytes
  localparam int LevelStep = 4;

  // Host bus request
  typedef struct packed {
    logic [NumChan-1:0] chanSelN;
    logic [2:0] addr;
    logic wrStrobe;
    logic rdStrobe;
    logic [7:0] wrData;
  } uxra_bus_t;

  // Per-channel FIFO fill state from the datapath
  typedef struct packed {
    logic [6:0] rxCount;
    logic [6:0] txFree;
    logic rxTimeout;
  } uxra_fifo_t;
endpackage

// [core/uxra_chan_regs.sv]
// One channel's extended register set and read mux
module uxra_chan_regs (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Decoded access
  input wire logic sel,
  input wire uxra_pkg::uxra_bus_t bus,
  // Register contents
  output logic [7:0] lineCtrl,
  output logic [7:0] modemCtrl,
  output logic [7:0] rdValue,
  output logic [15:0] divisor,
  output logic [7:0] threshold,
  output logic [7:0] trigLevel,
  output logic [7:0] enhCtrl,
  output logic [7:0] intEnable,
  output logic [7:0] fifoCtrl,
  output logic [7:0] stop1,
  output logic [7:0] stop2
);
  logic [7:0] lcr_q, mcr_q, efr_q, ier_q, fcr_q, dll_q, dlh_q;
  logic [7:0] tcr_q, tlr_q, xon1_q, xon2_q, xoff1_q, xoff2_q;
  wire wr = sel && bus.wrStrobe;
  wire keyBank = (lcr_q == uxra_pkg::LineEnhancedKey);
  wire divBank = lcr_q[uxra_pkg::LineDivLatchBit] && !keyBank;
  wire enh = efr_q[uxra_pkg::EnhEnableBit];
  wire tcrBank = !lcr_q[uxra_pkg::LineDivLatchBit] && enh && mcr_q[uxra_pkg::McrBankBit];
  wire sleepOff = !ier_q[uxra_pkg::SleepBit];
  wire [2:0] a = bus.addr;
  wire [7:0] d = bus.wrData;
  // Keep bits when enhanced writes are locked
  wire [7:0] mcrD = enh ? d : {mcr_q[7:5], d[4:0]};
  wire [7:0] ierD = enh ? d : {ier_q[7:4], d[3:0]};
  wire [7:0] fcrD = enh ? d : {d[7:6], fcr_q[5:4], d[3:0]};

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      lcr_q <= uxra_pkg::ResetLineCtrl;
      {mcr_q, efr_q, ier_q, fcr_q} <= {4{uxra_pkg::ResetByte}};
      {dlh_q, dll_q} <= uxra_pkg::ResetDivisor;
      {tcr_q, tlr_q, xon1_q, xon2_q, xoff1_q, xoff2_q} <= {6{uxra_pkg::ResetByte}};
    end else if (wr) begin
      if (a == uxra_pkg::AddrLineCtrl) lcr_q <= d;
      if (keyBank) begin
        if (a == uxra_pkg::AddrEnhanced) efr_q <= d;
        if (a == uxra_pkg::AddrResume1) xon1_q <= d;
        if (a == uxra_pkg::AddrResume2) xon2_q <= d;
        if (a == uxra_pkg::AddrStop1) xoff1_q <= d;
        if (a == uxra_pkg::AddrStop2) xoff2_q <= d;
      end else if (divBank) begin
        if (a == uxra_pkg::AddrDivLow && sleepOff) dll_q <= d;
        if (a == uxra_pkg::AddrDivHigh && sleepOff) dlh_q <= d;
      end else begin
        if (a == uxra_pkg::AddrModemCtrl) mcr_q <= mcrD;
        if (a == uxra_pkg::AddrIntEnable) ier_q <= ierD;
        if (a == uxra_pkg::AddrFifoCtrl) fcr_q <= fcrD;
        if (a == uxra_pkg::AddrThreshold && tcrBank) tcr_q <= d;
        if (a == uxra_pkg::AddrTrigger && tcrBank) tlr_q <= d;
      end
    end
  end

  // Read mux for this channel's banked registers
  always_comb begin
    rdValue = uxra_pkg::ResetByte;
    case (a)
      3'h0: rdValue = divBank ? dll_q : uxra_pkg::ResetByte;
      3'h1: rdValue = divBank ? dlh_q : (keyBank ? uxra_pkg::ResetByte : ier_q);
      3'h2: rdValue = keyBank ? efr_q : uxra_pkg::ResetByte;
      3'h3: rdValue = lcr_q;
      3'h4: rdValue = keyBank ? xon1_q : mcr_q;
      3'h5: rdValue = keyBank ? xon2_q : uxra_pkg::ResetByte;
      3'h6: rdValue = keyBank ? xoff1_q : (tcrBank ? tcr_q : uxra_pkg::ResetByte);
      3'h7: rdValue = keyBank ? xoff2_q : (tcrBank ? tlr_q : uxra_pkg::ResetByte);
      default: rdValue = uxra_pkg::ResetByte;
    endcase
  end

  assign lineCtrl = lcr_q;
  assign modemCtrl = mcr_q;
  assign divisor = {dlh_q, dll_q};
  assign threshold = tcr_q;
  assign trigLevel = tlr_q;
  assign enhCtrl = efr_q;
  assign intEnable = ier_q;
  assign fifoCtrl = fcr_q;
  assign stop1 = xoff1_q;
  assign stop2 = xoff2_q;
endmodule

// [core/uxra_top.sv]
// Extended register access for a four-channel UART, host bus side
//
// Operation
// - Divisor is 16 bits, kept in a low byte and a high byte.
// - Divisor bytes accept writes only while sleep enable is clear.
// - Flow threshold upper nibble is resume level, lower nibble halt level.
// - Threshold level in bytes is four times the nibble, 0 to 60.
// - Flow threshold writable only with enhanced enable and modem bit 6 set.
// - Trigger register: receive level upper nibble, transmit level lower nibble.
// - Trigger levels 4 to 60 in steps of four, nibble is level/4.
// - Trigger register writable only with enhanced enable and modem bit 6.
// - A zero trigger nibble falls back to the FIFO control selection.
// - Ready upper bits: receive count above trigger, or time-out.
// - Ready lower bits: transmit free space at least the trigger level.
// - Ready status at address 7 with any select low, bit 2 set, no loop-back, line control not BF.
// - Under line control BF, stop chars at 6/7, resume chars at 4/5.
// - Enhanced feature register reachable at 2 only under line control BF.
// - Modem bit 7 selects divide-by-4 prescaler, needs enhanced enable.
// - Enhanced enable clear locks upper INTERRUPT_ENABLE, FIFO_CONTROL 5:4 and MODEM_CONTROL 7:5.
// - Auto request goes high at halt level, low at resume level.
module uxra_top #(
  parameter int NumChan = uxra_pkg::NumChan
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Host register bus
  input wire uxra_pkg::uxra_bus_t bus,
  output logic [7:0] rdData,
  // FIFO state per channel
  input wire uxra_pkg::uxra_fifo_t [NumChan-1:0] fifo,
  // Per-channel configuration out
  output logic [NumChan-1:0][15:0] divisorOut,
  output logic [NumChan-1:0] prescaleDiv4,
  output logic [NumChan-1:0][6:0] rxTrigBytes,
  output logic [NumChan-1:0][6:0] txTrigBytes,
  output logic [NumChan-1:0][6:0] haltBytes,
  output logic [NumChan-1:0][6:0] resumeBytes,
  output logic [NumChan-1:0] reqToSendPin
);
  // Nibble to byte count, used for threshold levels and nonzero trigger nibbles
  function automatic logic [6:0] nibBytes(input logic [3:0] n);
    return {1'b0, n, 2'b00};
  endfunction

  // FIFO control trigger selections, two bits each
  function automatic logic [6:0] fcrRxLevel(input logic [1:0] s);
    case (s)
      2'h0: return 7'h08;
      2'h1: return 7'h10;
      2'h2: return 7'h38;
      default: return 7'h3c;
    endcase
  endfunction
  function automatic logic [6:0] fcrTxLevel(input logic [1:0] s);
    case (s)
      2'h0: return 7'h08;
      2'h1: return 7'h10;
      2'h2: return 7'h20;
      default: return 7'h38;
    endcase
  endfunction

  logic [NumChan-1:0][7:0] chRd, chLcr, chMcr, chTcr, chTlr, chEfr, chFcr;
  logic [NumChan-1:0][15:0] chDiv;
  logic [NumChan-1:0][6:0] rxTrig, txTrig, halt, resume;
  logic [NumChan-1:0] rxRdy, txRdy, rts_d;
  logic [NumChan-1:0] rts_q, pre_q;
  logic [NumChan-1:0][15:0] div_q;
  logic [NumChan-1:0][6:0] rxT_q, txT_q, halt_q, res_q;
  logic [7:0] rd_q;
  wire [NumChan-1:0] selN = bus.chanSelN;

  for (genvar c = 0; c < NumChan; c++) begin : g_ch
    uxra_chan_regs u_regs (
      .clock(clock),
      .rst(rst),
      .sel(!selN[c]),
      .bus(bus),
      .lineCtrl(chLcr[c]),
      .modemCtrl(chMcr[c]),
      .rdValue(chRd[c]),
      .divisor(chDiv[c]),
      .threshold(chTcr[c]),
      .trigLevel(chTlr[c]),
      .enhCtrl(chEfr[c]),
      .intEnable(),
      .fifoCtrl(chFcr[c]),
      .stop1(),
      .stop2()
    );
    assign halt[c] = nibBytes(chTcr[c][3:0]);
    assign resume[c] = nibBytes(chTcr[c][7:4]);
    assign rxTrig[c] = (chTlr[c][7:4] == 4'h0)
        ? fcrRxLevel(chFcr[c][uxra_pkg::FcrRxTrigLo +: 2])
        : nibBytes(chTlr[c][7:4]);
    assign txTrig[c] = (chTlr[c][3:0] == 4'h0)
        ? fcrTxLevel(chFcr[c][uxra_pkg::FcrTxTrigLo +: 2])
        : nibBytes(chTlr[c][3:0]);
    assign rxRdy[c] = (fifo[c].rxCount > rxTrig[c]) || fifo[c].rxTimeout;
    assign txRdy[c] = (fifo[c].txFree >= txTrig[c]);
    // Hysteresis holds the pin between the two levels
    assign rts_d[c] = !chEfr[c][uxra_pkg::EfrAutoReqBit] ? 1'b0
        : (fifo[c].rxCount >= halt[c]) ? 1'b1
        : (fifo[c].rxCount <= resume[c]) ? 1'b0
        : rts_q[c];
  end

  // First selected channel answers reads; ready view overrides at address 7
  logic [7:0] chanRd;
  logic anyReady;
  always_comb begin
    chanRd = 8'h00;
    anyReady = 1'b0;
    for (int c = NumChan - 1; c >= 0; c--) begin
      if (!selN[c]) begin
        chanRd = chRd[c];
        // Ready view ignores the bank bit, so it wins over the trigger register
        anyReady = chMcr[c][uxra_pkg::McrReadyEnBit] && !chMcr[c][uxra_pkg::McrLoopBit]
            && (chLcr[c] != uxra_pkg::LineEnhancedKey);
      end
    end
  end
  wire readyView = anyReady && (bus.addr == uxra_pkg::AddrReady);
  wire [7:0] readyByte = {4'(rxRdy), 4'(txRdy)};
  wire [7:0] rd_d = !bus.rdStrobe ? rd_q : (readyView ? readyByte : chanRd);

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rd_q <= 8'h00;
      rts_q <= '0;
      pre_q <= '0;
      div_q <= '0;
      rxT_q <= '0;
      txT_q <= '0;
      halt_q <= '0;
      res_q <= '0;
    end else begin
      rd_q <= rd_d;
      rts_q <= rts_d;
      for (int c = 0; c < NumChan; c++) begin
        pre_q[c] <= chMcr[c][uxra_pkg::McrPrescaleBit];
      end
      div_q <= chDiv;
      rxT_q <= rxTrig;
      txT_q <= txTrig;
      halt_q <= halt;
      res_q <= resume;
    end
  end

  assign rdData = rd_q;
  assign reqToSendPin = rts_q;
  assign prescaleDiv4 = pre_q;
  assign divisorOut = div_q;
  assign rxTrigBytes = rxT_q;
  assign txTrigBytes = txT_q;
  assign haltBytes = halt_q;
  assign resumeBytes = res_q;
endmodule

// [bench/uxra_checker.sv]
// Port assertions for the extended register block
module uxra_checker #(
  parameter int NumChan = 4
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Host bus
  input wire uxra_pkg::uxra_bus_t bus,
  input wire logic [7:0] rdData,
  // FIFO state and configuration
  input wire uxra_pkg::uxra_fifo_t [NumChan-1:0] fifo,
  input wire logic [NumChan-1:0][15:0] divisorOut,
  input wire logic [NumChan-1:0] prescaleDiv4,
  input wire logic [NumChan-1:0][6:0] rxTrigBytes,
  input wire logic [NumChan-1:0][6:0] txTrigBytes,
  input wire logic [NumChan-1:0][6:0] haltBytes,
  input wire logic [NumChan-1:0][6:0] resumeBytes,
  input wire logic [NumChan-1:0] reqToSendPin
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  thr_step_a: assert property (haltBytes[0][1:0] == 2'b00 && resumeBytes[0][1:0] == 2'b00)
    else $error("threshold bytes not a multiple of four");
  trig_range_a: assert property (!$past(rst) |-> rxTrigBytes[0] inside {[4:60]})
    else $error("receive trigger out of range");
  trig_nonzero_a: assert property (!$past(rst) |-> txTrigBytes[0] != 7'd0)
    else $error("transmit trigger is zero");
  div_cause_a: assert property (!$stable(divisorOut[0]) |->
    $past(bus.wrStrobe && !bus.chanSelN[0], 2))
    else $error("divisor changed without a write");
  thr_cause_a: assert property (!$stable(haltBytes[0]) |-> $past(bus.wrStrobe, 2))
    else $error("halt level changed without a write");
  pre_cause_a: assert property (!$stable(prescaleDiv4[0]) |->
    $past(bus.wrStrobe && bus.addr == uxra_pkg::AddrModemCtrl, 2))
    else $error("prescaler changed without a modem control write");
  rts_rise_a: assert property ($rose(reqToSendPin[0]) |->
    $past(fifo[0].rxCount) >= $past(haltBytes[0]))
    else $error("request rose below halt level");
  rts_fall_a: assert property ($fell(reqToSendPin[0]) |->
    $past(fifo[0].rxCount) <= $past(resumeBytes[0]))
    else $error("request fell above resume level");
  cover property ($rose(reqToSendPin[0]));
  cover property (!$stable(divisorOut[0]));
  cover property (bus.rdStrobe && bus.addr == uxra_pkg::AddrReady);
endmodule

bind uxra_top uxra_checker #(.NumChan(NumChan)) u_chk (.clock(clock), .rst(rst), .bus(bus),
  .rdData(rdData), .fifo(fifo), .divisorOut(divisorOut), .prescaleDiv4(prescaleDiv4),
  .rxTrigBytes(rxTrigBytes), .txTrigBytes(txTrigBytes), .haltBytes(haltBytes),
  .resumeBytes(resumeBytes), .reqToSendPin(reqToSendPin));

// [bench/uxra_host.sv]
// Host processor model on the register bus
module uxra_host (
  // Clock
  input wire logic clock,
  // Register bus
  output uxra_pkg::uxra_bus_t bus,
  input wire logic [7:0] rdData
);
  timeunit 1ns;
  timeprecision 1ps;
  initial bus = '{chanSelN: 4'hf, default: '0};
  // Idle bus shows inverted address and data, not the last values
  task automatic xfer(input logic w, input logic [2:0] a, input logic [7:0] d);
    @(posedge clock);
    #1 bus <= '{chanSelN: 4'he, addr: a, wrStrobe: w, rdStrobe: !w, wrData: d};
    @(posedge clock);
    #1 bus <= '{chanSelN: 4'hf, addr: ~a, wrStrobe: 1'b0, rdStrobe: 1'b0, wrData: ~d};
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    xfer(1'b0, a, 8'h00);
    d = rdData;
  endtask
endmodule

// [bench/tb.sv]
// Testbench for the extended register block
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [2:0] a; logic [7:0] d; logic [7:0] e;} uxra_row_t;
  localparam uxra_row_t Rows [12] = '{
    '{3'h3, 8'h80, 8'h80},
    '{3'h0, 8'h34, 8'h34},
    '{3'h1, 8'h12, 8'h12},
    '{3'h3, 8'hbf, 8'hbf},
    '{3'h2, 8'h50, 8'h50},
    '{3'h6, 8'haa, 8'haa},
    '{3'h4, 8'h55, 8'h55},
    '{3'h3, 8'h00, 8'h00},
    '{3'h4, 8'hc0, 8'hc0},
    '{3'h6, 8'h28, 8'h28},
    '{3'h7, 8'hf0, 8'hf0},
    '{3'h2, 8'h01, 8'h00}};
  logic clock = 1'b0;
  logic rst = 1'b1;
  uxra_pkg::uxra_bus_t bus;
  logic [7:0] rdData;
  logic [7:0] v;
  uxra_pkg::uxra_fifo_t [3:0] fifo = '0;
  logic [3:0][15:0] divisorOut;
  logic [3:0] prescaleDiv4;
  logic [3:0] reqToSendPin;
  logic [3:0][6:0] rxTrigBytes, txTrigBytes, haltBytes, resumeBytes;
  int fail_count = 0;
  int samples_checked = 0;
  int cycles = 0;
  uxra_host u_host (.clock(clock), .bus(bus), .rdData(rdData));
  uxra_top #(.NumChan(4)) u_dut (.clock(clock), .rst(rst), .bus(bus), .rdData(rdData),
    .fifo(fifo), .divisorOut(divisorOut), .prescaleDiv4(prescaleDiv4),
    .rxTrigBytes(rxTrigBytes), .txTrigBytes(txTrigBytes), .haltBytes(haltBytes),
    .resumeBytes(resumeBytes), .reqToSendPin(reqToSendPin));
  initial begin
    forever #12.5 clock = ~clock;
  end
  task automatic check(input string n, input logic [15:0] s, input logic [15:0] e);
    samples_checked++;
    if (s !== e) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic conclude();
    $display("checked %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      fail_count++;
      conclude();
    end
  end
  task automatic settle();
    repeat (2) @(posedge clock);
    #1;
  endtask
  initial begin
    repeat (20) @(posedge clock);
    #1 rst = 1'b0;
    u_host.rd(3'h3, v);
    check("line_control reset", v, 8'h1d);
    check("rx trigger reset", rxTrigBytes[0], 7'd8);
    foreach (Rows[i]) begin
      u_host.wr(Rows[i].a, Rows[i].d);
      u_host.rd(Rows[i].a, v);
      check("register", v, Rows[i].e);
    end
    check("divisor ch0", divisorOut[0], 16'h1234);
    check("divisor ch1", divisorOut[1], 16'h0000);
    check("halt", haltBytes[0], 7'd32);
    check("resume", resumeBytes[0], 7'd8);
    check("rx trigger", rxTrigBytes[0], 7'd60);
    check("tx trigger", txTrigBytes[0], 7'd8);
    check("prescale", prescaleDiv4[0], 1'b1);
    // Sleep locks the divisor
    u_host.wr(3'h1, 8'h10);
    u_host.wr(3'h3, 8'h80);
    u_host.wr(3'h0, 8'hff);
    u_host.rd(3'h0, v);
    check("divisor in sleep", v, 8'h34);
    u_host.wr(3'h3, 8'h00);
    u_host.wr(3'h1, 8'h00);
    // Request output with hysteresis between halt and resume
    fifo[0].rxCount = 7'd32;
    settle();
    check("request at halt", reqToSendPin[0], 1'b1);
    fifo[0].rxCount = 7'd20;
    settle();
    check("request held", reqToSendPin[0], 1'b1);
    fifo[0].rxCount = 7'd8;
    settle();
    check("request at resume", reqToSendPin[0], 1'b0);
    // Ready status, receive count at and above its trigger
    u_host.wr(3'h4, 8'h44);
    fifo[0].rxCount = 7'd60;
    fifo[1].rxTimeout = 1'b1;
    fifo[0].txFree = 7'd8;
    fifo[2].txFree = 7'd7;
    u_host.rd(3'h7, v);
    check("ready at trigger", v, 8'h21);
    fifo[0].rxCount = 7'd61;
    u_host.rd(3'h7, v);
    check("ready above trigger", v, 8'h31);
    check("prescale off", prescaleDiv4[0], 1'b0);
    // Drain first, so clearing auto request does not drop the pin above resume
    fifo[0].rxCount = 7'd0;
    settle();
    check("request released", reqToSendPin[0], 1'b0);
    // Enhanced enable cleared locks modem control upper bits
    u_host.wr(3'h3, 8'hbf);
    u_host.wr(3'h2, 8'h00);
    u_host.wr(3'h3, 8'h00);
    u_host.wr(3'h4, 8'he4);
    u_host.rd(3'h4, v);
    check("modem control locked", v, 8'h44);
    settle();
    check("prescale locked", prescaleDiv4[0], 1'b0);
    // Reset in mid-run restores the defaults
    rst = 1'b1;
    repeat (2) @(posedge clock);
    #1 rst = 1'b0;
    check("divisor after reset", divisorOut[0], 16'h0000);
    u_host.rd(3'h3, v);
    check("line_control after reset", v, 8'h1d);
    check("rx trigger after reset", rxTrigBytes[0], 7'd8);
    conclude();
  end
endmodule
